// file: src/fcb_chan_b_taps.sv
`default_nettype none
module fcb_chan_b_taps
	import fcb_pkg::*;
#(
	parameter int TAP_COEF_W = COEF_W
)
(
	// clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// axi4-lite write address
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	// axi4-lite write data and response
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	output logic [1:0]                         s_axi_bresp,
	// axi4-lite read
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	// coefficients toward the filter, index 0 is the sixth tap
	output logic                               dual_mode,
	output logic [NTAP-1:0][TAP_COEF_W-1:0]    chan_b_tap_coeff
);
	generate
		if (TAP_COEF_W != COEF_W || TAP_COEF_W >= CENTER_W) begin : g_chk
			$error("tap width must be the 12-bit outer tap width");
		end
	endgenerate

	fcb_bank_if bus ();

	fcb_coef_bank u_bank (
		.aclk    (aclk),
		.aresetn (aresetn),
		.bus     (bus)
	);

	logic                  aw_held_r, aw_held_nxt;
	logic                  w_held_r, w_held_nxt;
	logic [ADDR_W-1:0]     awaddr_r;
	logic [REG_W-1:0]      wdata_r;
	logic [1:0]            wstrb_r;
	logic                  awready_r, wready_r, arready_r;
	logic                  bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]            bresp_r, rresp_r;
	logic [31:0]           rdata_r;
	logic                  dual_mode_r;
	logic [NTAP-1:0][TAP_COEF_W-1:0] tap_out_r;

	// handshakes; the prot inputs carry no meaning here
	wire aw_take = s_axi_awvalid && awready_r;
	wire w_take  = s_axi_wvalid && wready_r;
	wire ar_take = s_axi_arvalid && arready_r;
	wire do_wr   = aw_held_r && w_held_r && !bvalid_r;
	assign aw_held_nxt = (aw_held_r || aw_take) && !do_wr;
	assign w_held_nxt  = (w_held_r || w_take) && !do_wr;
	assign bvalid_nxt  = do_wr || (bvalid_r && !s_axi_bready);
	assign rvalid_nxt  = ar_take || (rvalid_r && !s_axi_rready);

	// address decode, a write and a read comparator per tap
	wire [IDX_W-1:0] w_idx = awaddr_r[ADDR_W-1:2];
	wire [IDX_W-1:0] r_idx = s_axi_araddr[ADDR_W-1:2];
	wire [NTAP-1:0]  w_hit;
	wire [NTAP-1:0]  r_hit;
	wire [NTAP-1:0][31:0] r_word;
	genvar i;
	generate
		for (i = 0; i < NTAP; i++) begin : g_dec
			assign w_hit[i]  = (w_idx == TAP_IDX[i]);
			assign r_hit[i]  = (r_idx == TAP_IDX[i]);
			assign r_word[i] = r_hit[i] ?
				{16'h0000, bus.coef[i][RSV_MSB:RSV_LSB], 1'b0, bus.coef[i][COEF_MSB-1:0]} :
				32'h0000_0000;
		end
	endgenerate
	wire w_mode = (w_idx == IDX_MODE);
	wire r_mode = (r_idx == IDX_MODE);
	wire w_ok   = w_mode || (|w_hit);
	wire r_ok   = r_mode || (|r_hit);

	// at most one word is selected, so an or-reduction is the mux
	logic [31:0] rd_word;
	always_comb begin
		rd_word = r_mode ? {31'h0000_0000, dual_mode_r} : 32'h0000_0000;
		for (int k = 0; k < NTAP; k++) begin
			rd_word = rd_word | r_word[k];
		end
	end

	// write port toward the bank; only the low two lanes hold data
	assign bus.wr_en   = do_wr;
	assign bus.wr_hit  = w_hit;
	assign bus.wr_data = wdata_r;
	assign bus.wr_strb = wstrb_r;

	// write channels: address and data are latched in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			if (aw_take) begin
				awaddr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_r <= s_axi_wdata[REG_W-1:0];
				wstrb_r <= s_axi_wstrb[1:0];
			end
		end
	end

	// readies are registered so every bus output leaves a flop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			arready_r <= 1'b0;
		end else begin
			awready_r <= !aw_held_nxt && !bvalid_nxt;
			wready_r  <= !w_held_nxt && !bvalid_nxt;
			arready_r <= !rvalid_nxt;
		end
	end

	// responses; unmapped addresses answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end else begin
			bvalid_r <= bvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (do_wr) begin
				bresp_r <= w_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (ar_take) begin
				rresp_r <= r_ok ? RESP_OKAY : RESP_SLVERR;
				rdata_r <= rd_word;
			end
		end
	end

	// mode bit; while clear the taps show zero, so a set loaded before setting it reaches the filter whole; while set a tap write lands two clocks later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dual_mode_r <= DUAL_RST;
		end else if (do_wr && w_mode && wstrb_r[0]) begin
			dual_mode_r <= wdata_r[MODE_DUAL_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tap_out_r <= '0;
		end else begin
			for (int k = 0; k < NTAP; k++) begin
				tap_out_r[k] <= dual_mode_r ? bus.coef[k][COEF_W-1:0] : '0;
			end
		end
	end

	assign s_axi_awready    = awready_r;
	assign s_axi_wready     = wready_r;
	assign s_axi_bvalid     = bvalid_r;
	assign s_axi_bresp      = bresp_r;
	assign s_axi_arready    = arready_r;
	assign s_axi_rvalid     = rvalid_r;
	assign s_axi_rdata      = rdata_r;
	assign s_axi_rresp      = rresp_r;
	assign dual_mode        = dual_mode_r;
	assign chan_b_tap_coeff = tap_out_r;

	property p_rd_msb;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_rdata[COEF_MSB];
	endproperty
	a_rd_msb: assert property (p_rd_msb) else $error("readback msb not zero");

	property p_rd_upper;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> (s_axi_rdata[31:16] == 16'h0000);
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");

	property p_tap6;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && w_hit[0] && (&wstrb_r) && dual_mode_r)
			|-> ##2 (chan_b_tap_coeff[0] == $past(wdata_r[COEF_W-1:0], 2));
	endproperty
	a_tap6: assert property (p_tap6) else $error("sixth tap not applied");

	property p_tap7;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && (w_idx == IDX_TAP7) && (&wstrb_r) && dual_mode_r)
			|-> ##2 (chan_b_tap_coeff[1] == $past(wdata_r[COEF_W-1:0], 2));
	endproperty
	a_tap7: assert property (p_tap7) else $error("seventh tap not applied");

	property p_tap8;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && (w_idx == IDX_TAP8) && (&wstrb_r) && dual_mode_r)
			|-> ##2 (chan_b_tap_coeff[2] == $past(wdata_r[COEF_W-1:0], 2));
	endproperty
	a_tap8: assert property (p_tap8) else $error("eighth tap not applied");

	property p_tap9;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && (w_idx == IDX_TAP9) && (&wstrb_r) && dual_mode_r)
			|-> ##2 (chan_b_tap_coeff[3] == $past(wdata_r[COEF_W-1:0], 2));
	endproperty
	a_tap9: assert property (p_tap9) else $error("ninth tap not applied");

	property p_reset_out;
		@(posedge aclk) disable iff (1'b0)
		!aresetn |=> (chan_b_tap_coeff == '0) && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not clear after reset");

	property p_bvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

	property p_rvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");
endmodule
`default_nettype wire

// file: include/fcb_pkg.sv
`default_nettype none
package fcb_pkg;
	// register shape
	localparam int          NTAP      = 4;
	localparam int          REG_W     = 16;
	localparam int          COEF_W    = 12;
	localparam int          COEF_MSB  = 11;
	localparam int          RSV_LSB   = 12;
	localparam int          RSV_MSB   = 15;
	localparam int          CENTER_W  = 18;
	localparam int          ADDR_W    = 14;
	localparam int          IDX_W     = 12;
	localparam logic [REG_W-1:0] COEF_RST = 16'h0000;
	localparam logic        DUAL_RST  = 1'b0;
	localparam int          MODE_DUAL_BIT = 0;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_MODE = 12'h000;
	localparam logic [IDX_W-1:0] IDX_TAP6 = 12'h453;
	localparam logic [IDX_W-1:0] IDX_TAP7 = 12'h455;
	localparam logic [IDX_W-1:0] IDX_TAP8 = 12'h457;
	localparam logic [IDX_W-1:0] IDX_TAP9 = 12'h459;
	localparam logic [NTAP-1:0][IDX_W-1:0] TAP_IDX = {IDX_TAP9, IDX_TAP8, IDX_TAP7, IDX_TAP6};
	// bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: include/fcb_bank_if.sv
`default_nettype none
interface fcb_bank_if;
	import fcb_pkg::*;
	logic                        wr_en;
	logic [NTAP-1:0]             wr_hit;
	logic [REG_W-1:0]            wr_data;
	logic [1:0]                  wr_strb;
	logic [NTAP-1:0][REG_W-1:0]  coef;
	modport ctrl (output wr_en, output wr_hit, output wr_data, output wr_strb, input coef);
	modport bank (input wr_en, input wr_hit, input wr_data, input wr_strb, output coef);
endinterface
`default_nettype wire

// file: src/fcb_coef_bank.sv
`default_nettype none
module fcb_coef_bank
	import fcb_pkg::*;
(
	// clock and reset
	input  wire logic  aclk,
	input  wire logic  aresetn,
	// register port
	fcb_bank_if.bank   bus
);
	genvar i;
	generate
		for (i = 0; i < NTAP; i++) begin : g_tap
			logic [REG_W-1:0] coef_r;
			// byte lanes write independently; reserved bits are stored like the rest
			// field layout and reset
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					coef_r <= COEF_RST;
				end else if (bus.wr_en && bus.wr_hit[i]) begin
					if (bus.wr_strb[0]) begin
						coef_r[7:0] <= bus.wr_data[7:0];
					end
					if (bus.wr_strb[1]) begin
						coef_r[15:8] <= bus.wr_data[15:8];
					end
				end
			end
			assign bus.coef[i] = coef_r;
		end
	endgenerate

	// reset leaves every word cleared
	property p_bank_reset;
		@(posedge aclk) disable iff (1'b0)
		!aresetn |=> (bus.coef == '0);
	endproperty
	a_bank_reset: assert property (p_bank_reset) else $error("coefficient not zero after reset");
endmodule
`default_nettype wire

// file: tb/fcb_chan_b_taps_test.sv
`default_nettype none
module fcb_chan_b_taps_test
	import fcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// bench state
	logic                             aclk = 1'b0;
	logic                             aresetn = 1'b0;
	logic                             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                             arvalid = 1'b0, rready = 1'b0;
	logic [ADDR_W-1:0]                awaddr = '0, araddr = '0;
	logic [31:0]                      wdata = '0;
	logic [3:0]                       wstrb = '0;
	logic                             awready, wready, bvalid, arready, rvalid, dual_mode;
	logic [1:0]                       bresp, rresp;
	logic [31:0]                      rdata;
	logic [NTAP-1:0][COEF_W-1:0]      chan_b_tap_coeff;
	logic [33:0]                      exp_r[$];
	logic [1:0]                       exp_b[$];
	logic [15:0]                      v [NTAP];
	logic [31:0]                      rnd;
	int                               err_count = 0, cmp_count = 0, seed = 75931;
	// 100 MHz clock
	always #5 aclk = ~aclk;
	fcb_chan_b_taps dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .dual_mode(dual_mode), .chan_b_tap_coeff(chan_b_tap_coeff));
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// readback hides the coefficient sign bit, reserved bits come back as written
	function automatic logic [31:0] rb(input logic [15:0] d);
		return {16'h0000, d[15:12], 1'b0, d[10:0]};
	endfunction
	function automatic logic [13:0] tap_a(input int i);
		return {TAP_IDX[i], 2'b00};
	endfunction
	task automatic axi_wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int n;
		bit ta, tw;
		n = 0;
		ta = 0;
		tw = 0;
		exp_b.push_back(r);
		awaddr <= a; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		// each channel is released at its own take edge
		do begin
			@(posedge aclk);
			n++;
			if (awready && !ta) begin ta = 1; awvalid <= 1'b0; end
			if (wready && !tw) begin tw = 1; wvalid <= 1'b0; end
		end while (!(ta && tw) && n < 50);
		while (!bvalid && n < 50) begin @(posedge aclk); n++; end
		bready <= 1'b0;
		if (n >= 50) begin err_count++; wrap_up(); end
		// let an edge pass so the next call never re-raises bready in this step
		@(posedge aclk);
	endtask
	task automatic axi_rd(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		n = 0;
		exp_r.push_back({r, d});
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin @(posedge aclk); n++; end while (!arready && n < 50);
		arvalid <= 1'b0;
		while (!rvalid && n < 50) begin @(posedge aclk); n++; end
		rready <= 1'b0;
		if (n >= 50) begin err_count++; wrap_up(); end
		// let an edge pass so the next call never re-raises rready in this step
		@(posedge aclk);
	endtask
	// filter-side taps and readback of every tap register
	task automatic tap_chk(input logic on);
		repeat (2) @(posedge aclk);
		#1;
		check(dual_mode, on);
		for (int i = 0; i < NTAP; i++) begin
			check(chan_b_tap_coeff[i], on ? v[i][11:0] : '0);
		end
		@(posedge aclk);
		for (int i = 0; i < NTAP; i++) axi_rd(tap_a(i), rb(v[i]), RESP_OKAY);
	endtask
	// monitor pairs each answer with the oldest noted expectation
	always @(posedge aclk) begin
		if (bvalid && bready && exp_b.size() > 0) check(bresp, exp_b.pop_front());
		if (rvalid && rready && exp_r.size() > 0) check({rresp, rdata}, exp_r.pop_front());
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// all taps and the mode bit start at zero
		for (int i = 0; i < NTAP; i++) v[i] = 16'h0000;
		tap_chk(1'b0);
		axi_rd(14'h0000, 32'h0, RESP_OKAY);
		$display("test reset_values done");
		// random coefficients stay off the filter while the mode bit is clear
		for (int i = 0; i < NTAP; i++) begin
			v[i] = 16'($random(seed));
			axi_wr(tap_a(i), {16'hFFFF, v[i]}, 4'hF, RESP_OKAY);
		end
		tap_chk(1'b0);
		$display("test mode_off done");
		axi_wr(14'h0000, 32'h1, 4'hF, RESP_OKAY);
		axi_rd(14'h0000, 32'h1, RESP_OKAY);
		tap_chk(1'b1);
		$display("test mode_on done");
		// full-width rewrite while the filter is live; upper strobes stay clear
		for (int i = 0; i < NTAP; i++) begin
			v[i] = 16'($random(seed));
			axi_wr(tap_a(i), {16'h0000, v[i]}, 4'h3, RESP_OKAY);
		end
		tap_chk(1'b1);
		$display("test live_update done");
		// low byte lane only: upper byte of the seventh tap keeps its value
		rnd = 32'($random(seed));
		v[1] = {v[1][15:8], rnd[7:0]};
		axi_wr(tap_a(1), rnd, 4'h1, RESP_OKAY);
		tap_chk(1'b1);
		$display("test byte_lane done");
		// even index between taps is not a register
		axi_wr({IDX_TAP6 + 12'h001, 2'b00}, 32'hFFFF, 4'hF, RESP_SLVERR);
		axi_rd({IDX_TAP6 + 12'h001, 2'b00}, 32'h0, RESP_SLVERR);
		tap_chk(1'b1);
		$display("test unmapped done");
		axi_wr(14'h0000, 32'h0, 4'hF, RESP_OKAY);
		tap_chk(1'b0);
		$display("test mode_clear done");
		repeat (3) @(posedge aclk);
		wrap_up();
	end
endmodule
`default_nettype wire
